/* design/exc_vec_regs.vh */
// constants for the exception vectoring unit
`ifndef EXC_VEC_REGS_VH
`define EXC_VEC_REGS_VH
// reference class codes
`define RC_USER_DATA      3'h1
`define RC_USER_PROG      3'h2
`define RC_SUPV_DATA      3'h5
`define RC_SUPV_PROG      3'h6
`define RC_INT_ACK        3'h7
// vector numbers
`define VN_RESET          8'h00
`define VN_RESET_PC       8'h01
`define VN_BUS_ERR        8'h02
`define VN_ADDR_ERR       8'h03
`define VN_ILLEGAL        8'h04
`define VN_ZERO_DIV       8'h05
`define VN_BOUNDS         8'h06
`define VN_TRAP_ON_OVERFLOW_INSTR          8'h07
`define VN_PRIV           8'h08
`define VN_TRACE          8'h09
`define VN_LINE_A         8'h0a
`define VN_LINE_F         8'h0b
`define VN_UNINIT         8'h0f
`define VN_SPURIOUS       8'h18
`define VN_AUTO_BASE      8'h18
`define VN_TRAP_BASE      8'h20
`define VN_USER_FIRST     8'h40
// status register fields
`define SR_S_BIT          15
`define SR_T_BIT          14
`define SR_MASK_HI        10
`define SR_MASK_LO        8
`define IPL_MAX           3'h7
// vector address layout
`define VEC_ADDR_SHIFT    2
`define VEC_TABLE_LAST    24'h0003ff
`define ABORT_LIMIT       2
`define STACK_WORDS       3'h3
`define STACK_WORDS_ERR   3'h6
// opcode lines with their own emulation vectors
`define OPLINE_A          4'ha
`define OPLINE_F          4'hf
// cause codes
`define C_NONE            4'h0
`define C_RESET           4'h1
`define C_BUS_ERR         4'h2
`define C_ADDR_ERR        4'h3
`define C_TRACE           4'h4
`define C_INT             4'h5
`define C_ILLEGAL         4'h6
`define C_PRIV            4'h7
`define C_LINE_A          4'h8
`define C_LINE_F          4'h9
`define C_TRAP            4'ha
`define C_TRAP_ON_OVERFLOW_INSTR           4'hb
`define C_BOUNDS          4'hc
`define C_ZERO_DIV        4'hd
`endif

/* design/exc_priority.v */
// priority resolver for simultaneous exception causes
`timescale 1ns/100ps
`default_nettype none
`include "exc_vec_regs.vh"
module exc_priority (
  input  wire       reset_req,
  input  wire       bus_err,
  input  wire       addr_err,
  input  wire       trace_pend,
  input  wire       int_pend,
  input  wire       illegal,
  input  wire       priv_viol,
  input  wire       line_a,
  input  wire       line_f,
  input  wire       instr_trap,
  input  wire       trap_on_overflow_instr_trap,
  input  wire       bounds_trap,
  input  wire       zero_div,
  output reg  [3:0] cause,
  output wire       abort_class
);
  // abort class first, then completion class, then instruction-raised
  assign abort_class = reset_req | bus_err | addr_err;
  always @* begin
    if (reset_req)        cause = `C_RESET;
    else if (bus_err)     cause = `C_BUS_ERR;
    else if (addr_err)    cause = `C_ADDR_ERR;
    else if (trace_pend)  cause = `C_TRACE;
    else if (int_pend)    cause = `C_INT;
    else if (illegal)     cause = `C_ILLEGAL;
    else if (priv_viol)   cause = `C_PRIV;
    else if (line_a)      cause = `C_LINE_A;
    else if (line_f)      cause = `C_LINE_F;
    else if (instr_trap)  cause = `C_TRAP;
    else if (trap_on_overflow_instr_trap)  cause = `C_TRAP_ON_OVERFLOW_INSTR;
    else if (bounds_trap) cause = `C_BOUNDS;
    else if (zero_div)    cause = `C_ZERO_DIV;
    else                  cause = `C_NONE;
  end
endmodule // exc_priority
`default_nettype wire

/* design/exc_vector_map.v */
// internal vector number generator and vector address former
`timescale 1ns/100ps
`default_nettype none
`include "exc_vec_regs.vh"
module exc_vector_map (
  input  wire [3:0]  cause,
  input  wire [3:0]  trap_num,
  input  wire [2:0]  int_level,
  input  wire [7:0]  vec_num,
  output reg  [7:0]  int_vec_num,
  output wire [7:0]  autovec_num,
  output wire [23:0] vec_addr
);
  always @* begin
    case (cause)
      `C_RESET:    int_vec_num = `VN_RESET;
      `C_BUS_ERR:  int_vec_num = `VN_BUS_ERR;
      `C_ADDR_ERR: int_vec_num = `VN_ADDR_ERR;
      `C_TRACE:    int_vec_num = `VN_TRACE;
      `C_ILLEGAL:  int_vec_num = `VN_ILLEGAL;
      `C_PRIV:     int_vec_num = `VN_PRIV;
      `C_LINE_A:   int_vec_num = `VN_LINE_A;
      `C_LINE_F:   int_vec_num = `VN_LINE_F;
      `C_TRAP:     int_vec_num = `VN_TRAP_BASE | {4'h0, trap_num};
      `C_TRAP_ON_OVERFLOW_INSTR:    int_vec_num = `VN_TRAP_ON_OVERFLOW_INSTR;
      `C_BOUNDS:   int_vec_num = `VN_BOUNDS;
      `C_ZERO_DIV: int_vec_num = `VN_ZERO_DIV;
      default:     int_vec_num = `VN_SPURIOUS;
    endcase
  end
  // autovector for levels 1..7 is 25..31
  assign autovec_num = `VN_AUTO_BASE + {5'h00, int_level};
  // number times four, upper bits zero, always within the table
  assign vec_addr = {14'h0000, vec_num, 2'h0};
endmodule // exc_vector_map
`default_nettype wire

/* design/exception_vectoring_unit.v */
// exception sequencer: reference class, vector fetch, stacking, new context
`timescale 1ns/100ps
`default_nettype none
`include "exc_vec_regs.vh"
module exception_vectoring_unit (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        clk_en,
  // core-side status
  input  wire [15:0] status_reg,
  input  wire [23:0] pc,
  input  wire [23:0] supervisor_stack_pointer,
  input  wire        instr_done,
  input  wire        cpu_data_ref,
  // exception sources
  input  wire        reset_req,
  input  wire        bus_err,
  input  wire        word_fetch,
  input  wire [23:0] fetch_addr,
  input  wire        illegal_op,
  input  wire        privileged_op,
  input  wire [3:0]  opcode_line,
  input  wire        trap_instr,
  input  wire [3:0]  trap_num,
  input  wire        trap_on_overflow_instr,
  input  wire        bounds_check_instr,
  input  wire        zero_div,
  input  wire [2:0]  int_level,
  // bus cycle handshake
  input  wire        bus_done,
  input  wire        bus_autovec,
  input  wire        bus_fault,
  input  wire [15:0] bus_rdata,
  output reg         bus_req,
  output reg         bus_write,
  output reg  [23:0] bus_addr,
  output reg  [15:0] bus_wdata,
  output wire        ref_class_bit0,
  output wire        ref_class_bit1,
  output wire        ref_class_bit2,
  // new context to the core
  output reg  [15:0] new_status,
  output reg  [23:0] new_pc,
  output reg  [23:0] new_ssp,
  output reg         ctx_load,
  output reg         exc_active,
  output reg  [7:0]  vec_num_q,
  output reg         start_fetch
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_PREP  = 8'h02;
  localparam [7:0] S_IACK  = 8'h04;
  localparam [7:0] S_STACK = 8'h08;
  localparam [7:0] S_VECHI = 8'h10;
  localparam [7:0] S_VECLO = 8'h20;
  localparam [7:0] S_LOAD  = 8'h40;
  localparam [7:0] S_HALT  = 8'h80;

  reg  [7:0]  state_q;
  reg  [3:0]  cause_q;
  reg  [15:0] sr_copy_q;
  reg  [23:0] sp_q;
  reg  [2:0]  step_q;
  reg  [2:0]  ref_class_q;
  reg         reset_pc_q;
  reg         int_pend_q;
  reg         trace_pend_q;
  reg  [15:0] hi_word_q;
  reg  [23:0] fault_addr_q;
  reg  [3:0]  trap_num_q;

  wire [3:0]  cause;
  wire        abort_class;
  wire [7:0]  int_vec_num;
  wire [7:0]  autovec_num;
  wire [23:0] vec_addr;
  wire [2:0]  mask = status_reg[`SR_MASK_HI:`SR_MASK_LO];
  wire        addr_err = word_fetch & fetch_addr[0];
  wire        int_req = (int_level > mask) | (int_level == `IPL_MAX);
  wire        at_boundary = instr_done;
  wire        is_reset = (cause_q == `C_RESET);
  wire        is_group0_err = (cause_q == `C_BUS_ERR) | (cause_q == `C_ADDR_ERR);
  wire [2:0]  words_to_stack = is_group0_err ? `STACK_WORDS_ERR : `STACK_WORDS;
  wire        line_a = illegal_op & (opcode_line == `OPLINE_A);
  wire        line_f = illegal_op & (opcode_line == `OPLINE_F);
  // a traced instruction owes its trace at this boundary, ahead of interrupts
  wire        trace_now = (trace_pend_q | status_reg[`SR_T_BIT]) & at_boundary;

  // ----------------------------------------------------------------
  // priority and vector number
  // ----------------------------------------------------------------
  exc_priority u_prio (
    .reset_req   (reset_req),
    .bus_err     (bus_err),
    .addr_err    (addr_err),
    .trace_pend  (trace_now),
    .int_pend    (int_req & at_boundary),
    .illegal     (illegal_op & ~line_a & ~line_f & at_boundary),
    .priv_viol   (privileged_op & ~status_reg[`SR_S_BIT] & at_boundary),
    .line_a      (line_a & at_boundary),
    .line_f      (line_f & at_boundary),
    .instr_trap  (trap_instr),
    .trap_on_overflow_instr_trap  (trap_on_overflow_instr),
    .bounds_trap (bounds_check_instr),
    .zero_div    (zero_div),
    .cause       (cause),
    .abort_class (abort_class)
  );

  exc_vector_map u_map (
    .cause       (cause_q),
    .trap_num    (trap_num_q),
    .int_level   (int_level),
    .vec_num     (vec_num_q),
    .int_vec_num (int_vec_num),
    .autovec_num (autovec_num),
    .vec_addr    (vec_addr)
  );

  // supervisor data for vector fetches, supervisor program for reset
  function [2:0] fetch_class;
    input rst;
    begin
      fetch_class = rst ? `RC_SUPV_PROG : `RC_SUPV_DATA;
    end
  endfunction

  // idle references follow the privilege state
  wire [2:0] idle_class = {status_reg[`SR_S_BIT], ~cpu_data_ref, cpu_data_ref};
  wire [2:0] ref_class  = (state_q == S_IDLE) ? idle_class : ref_class_q;
  assign ref_class_bit0 = ref_class[0];
  assign ref_class_bit1 = ref_class[1];
  assign ref_class_bit2 = ref_class[2];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= S_IDLE;
      cause_q      <= `C_NONE;
      sr_copy_q    <= 16'h0000;
      sp_q         <= 24'h000000;
      step_q       <= 3'h0;
      ref_class_q  <= `RC_SUPV_PROG;
      reset_pc_q   <= 1'b0;
      int_pend_q   <= 1'b0;
      trace_pend_q <= 1'b0;
      hi_word_q    <= 16'h0000;
      fault_addr_q <= 24'h000000;
      trap_num_q   <= 4'h0;
      bus_req      <= 1'b0;
      bus_write    <= 1'b0;
      bus_addr     <= 24'h000000;
      bus_wdata    <= 16'h0000;
      new_status   <= 16'h0000;
      new_pc       <= 24'h000000;
      new_ssp      <= 24'h000000;
      ctx_load     <= 1'b0;
      exc_active   <= 1'b0;
      vec_num_q    <= 8'h00;
      start_fetch  <= 1'b0;
    end else if (clk_en) begin
      ctx_load    <= 1'b0;
      start_fetch <= 1'b0;
      // trace armed per instruction while tracing is on
      if (instr_done && status_reg[`SR_T_BIT])
        trace_pend_q <= 1'b1;
      if (reset_req || bus_err || addr_err) begin
        // abort whatever runs; status phase starts next edge
        if (state_q != S_IDLE && !reset_req && cause_q != `C_RESET &&
            cause_q != `C_INT) begin
          state_q <= S_HALT;                                     // double fault
        end else begin
          state_q <= S_PREP;
          cause_q <= cause;
        end
        fault_addr_q <= fetch_addr;
        bus_req      <= 1'b0;
        exc_active   <= 1'b1;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (cause != `C_NONE && !abort_class) begin
              cause_q    <= cause;
              trap_num_q <= trap_num;
              state_q    <= S_PREP;
              exc_active <= 1'b1;
              if (cause == `C_TRACE) begin
                trace_pend_q <= 1'b0;
                int_pend_q   <= int_req;
              end
            end else if (int_pend_q) begin
              cause_q    <= `C_INT;
              int_pend_q <= 1'b0;
              state_q    <= S_PREP;
              exc_active <= 1'b1;
            end
          end
          S_PREP: begin
            // phase one: copy status, enter supervisor, drop trace
            sr_copy_q <= status_reg;
            new_status <= status_reg;
            new_status[`SR_S_BIT] <= 1'b1;
            new_status[`SR_T_BIT] <= 1'b0;
            if (is_reset)
              new_status[`SR_MASK_HI:`SR_MASK_LO] <= `IPL_MAX;
            else if (cause_q == `C_INT)
              new_status[`SR_MASK_HI:`SR_MASK_LO] <= int_level;
            sp_q <= supervisor_stack_pointer;
            if (cause_q == `C_INT) begin
              // phase two: acknowledge cycle shows the level on the address
              state_q     <= S_IACK;
              bus_req     <= 1'b1;
              bus_write   <= 1'b0;
              bus_addr    <= {20'h00000, int_level, 1'b1};
              ref_class_q <= `RC_INT_ACK;
            end else begin
              vec_num_q <= int_vec_num;
              step_q    <= 3'h0;
              state_q   <= is_reset ? S_VECHI : S_STACK;
            end
          end
          S_IACK: begin
            if (bus_done) begin
              bus_req <= 1'b0;
              if (bus_fault)
                vec_num_q <= `VN_SPURIOUS;
              else if (bus_autovec)
                vec_num_q <= autovec_num;
              else
                vec_num_q <= bus_rdata[7:0];
              step_q  <= 3'h0;
              state_q <= S_STACK;
            end
          end
          S_STACK: begin
            // phase three: pc low, pc high, status, then extra error words
            if (!bus_req) begin
              bus_req     <= 1'b1;
              bus_write   <= 1'b1;
              ref_class_q <= `RC_SUPV_DATA;
              bus_addr    <= sp_q - 24'h000002;
              sp_q        <= sp_q - 24'h000002;
              case (step_q)
                3'h0:    bus_wdata <= pc[15:0];
                3'h1:    bus_wdata <= {8'h00, pc[23:16]};
                3'h2:    bus_wdata <= sr_copy_q;
                3'h3:    bus_wdata <= fault_addr_q[15:0];
                3'h4:    bus_wdata <= {8'h00, fault_addr_q[23:16]};
                default: bus_wdata <= {4'h0, cause_q, vec_num_q};
              endcase
            end else if (bus_done) begin
              bus_req <= 1'b0;
              if (step_q == words_to_stack - 3'h1) begin
                step_q  <= 3'h0;
                state_q <= S_VECHI;
              end else begin
                step_q <= step_q + 3'h1;
              end
            end
          end
          S_VECHI: begin
            // phase four: two-word handler address from the vector entry
            if (!bus_req) begin
              bus_req     <= 1'b1;
              bus_write   <= 1'b0;
              ref_class_q <= fetch_class(is_reset);
              bus_addr    <= vec_addr + {20'h00000, step_q, 1'b0};
            end else if (bus_done) begin
              bus_req   <= 1'b0;
              hi_word_q <= bus_rdata;
              step_q    <= step_q + 3'h1;
              state_q   <= S_VECLO;
            end
          end
          S_VECLO: begin
            if (!bus_req) begin
              bus_req  <= 1'b1;
              bus_addr <= vec_addr + {20'h00000, step_q, 1'b0};
            end else if (bus_done) begin
              bus_req <= 1'b0;
              step_q  <= step_q + 3'h1;
              if (is_reset && !reset_pc_q) begin
                // reset entry: first pair is the stack pointer
                new_ssp    <= {hi_word_q[7:0], bus_rdata};
                reset_pc_q <= 1'b1;
                state_q    <= S_VECHI;
              end else begin
                new_pc     <= {hi_word_q[7:0], bus_rdata};
                if (!is_reset)
                  new_ssp  <= sp_q;
                reset_pc_q <= 1'b0;
                state_q    <= S_LOAD;
              end
            end
          end
          S_LOAD: begin
            ctx_load    <= 1'b1;
            start_fetch <= 1'b1;
            exc_active  <= 1'b0;
            ref_class_q <= `RC_SUPV_PROG;
            state_q     <= S_IDLE;
          end
          S_HALT: begin
            bus_req <= 1'b0;
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // exception_vectoring_unit
`default_nettype wire

/* testbench/exc_vec_checker.sv */
// port assertions for the exception vectoring unit
`timescale 1ns/100ps
`default_nettype none
module exc_vec_checker (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire logic        bus_err,
  input wire logic        word_fetch,
  input wire logic [23:0] fetch_addr,
  input wire logic        bus_done,
  input wire logic        bus_req,
  input wire logic        bus_write,
  input wire logic [23:0] bus_addr,
  input wire logic        ref_class_bit0,
  input wire logic        ref_class_bit1,
  input wire logic        ref_class_bit2,
  input wire logic [15:0] new_status,
  input wire logic        ctx_load,
  input wire logic        exc_active,
  input wire logic [7:0]  vec_num_q,
  input wire logic        start_fetch
);
  wire [2:0] rc = {ref_class_bit2, ref_class_bit1, ref_class_bit0};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_class_legal: assert property (rc != 3'h0 && rc != 3'h3 && rc != 3'h4)
    else $error("reference class uses an unassigned code");
  a_abort_start: assert property ((clk_en && !exc_active && (bus_err || (word_fetch && fetch_addr[0])))
    |-> ##[1:2] exc_active) else $error("abort cause not started within two cycles");
  a_vec_addr: assert property (bus_req && !bus_write && rc == 3'h5
    |-> bus_addr[23:2] == {14'h0, vec_num_q} && !bus_addr[0]) else $error("vector address wrong");
  a_stack_class: assert property (bus_req && bus_write |-> rc == 3'h5)
    else $error("stack write not supervisor data");
  a_ack_read: assert property (bus_req && rc == 3'h7 |-> !bus_write && bus_addr[23:4] == 20'h0)
    else $error("acknowledge cycle malformed");
  a_req_hold: assert property (bus_req && !bus_done && clk_en
    |=> bus_req && $stable(bus_addr) && $stable(bus_write)) else $error("bus request dropped early");
  a_ctx_status: assert property (ctx_load |-> new_status[15] && !new_status[14])
    else $error("new status not supervisor without trace");
  a_ctx_fetch: assert property (ctx_load |-> ##[0:1] start_fetch)
    else $error("no instruction fetch after new context");
  a_ctx_once: assert property (ctx_load |=> !ctx_load)
    else $error("context load longer than one cycle");
endmodule // exc_vec_checker
bind exception_vectoring_unit exc_vec_checker chk (.core_clk, .rstn, .clk_en, .bus_err,
  .word_fetch, .fetch_addr, .bus_done, .bus_req, .bus_write, .bus_addr, .ref_class_bit0,
  .ref_class_bit1, .ref_class_bit2, .new_status, .ctx_load, .exc_active, .vec_num_q,
  .start_fetch);
`default_nettype wire

/* testbench/exc_bus_model.sv */
// bus partner: interrupting peripheral and vector memory
`timescale 1ns/100ps
`default_nettype none
module exc_bus_model (
  input  wire logic        core_clk,
  input  wire logic        bus_req,
  input  wire logic        bus_write,
  input  wire logic [23:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic [2:0]  ref_class,
  input  wire logic [7:0]  ack_vec,
  input  wire logic [1:0]  ack_kind,
  input  wire logic [1:0]  lat,
  output logic             bus_done,
  output logic             bus_autovec,
  output logic             bus_fault,
  output logic [15:0]      bus_rdata
);
  logic [15:0] wlog [0:63];
  int          wr_n = 0;
  int          rd6_n = 0;
  logic [1:0]  cnt = 2'h0;
  initial {bus_done, bus_autovec, bus_fault, bus_rdata} = '0;
  always @(posedge core_clk) begin
    bus_done <= 1'b0;
    bus_autovec <= 1'b0;
    bus_fault <= 1'b0;
    bus_rdata <= ~bus_rdata;  // released data lines never hold the last value
    if (bus_req && !bus_done) begin
      cnt <= cnt + 2'h1;
      if (cnt == lat) begin
        cnt <= 2'h0;
        bus_done <= 1'b1;
        if (bus_write) begin
          wlog[wr_n[5:0]] <= bus_wdata;
          wr_n <= wr_n + 1;
        end else if (ref_class == 3'h7) begin
          bus_rdata <= {8'h5a, ack_vec};
          bus_autovec <= ack_kind == 2'h1;
          bus_fault <= ack_kind == 2'h2;
        end else begin
          if (ref_class == 3'h6)
            rd6_n <= rd6_n + 1;
          bus_rdata <= {~bus_addr[7:0], bus_addr[7:0]};
        end
      end
    end
  end
endmodule // exc_bus_model
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the exception vectoring unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        core_clk = 0, rstn = 0, instr_done = 0, cpu_data_ref = 1, reset_req = 0;
  logic        bus_err = 0, word_fetch = 0, illegal_op = 0, privileged_op = 0, trap_instr = 0;
  logic        trap_on_overflow_instr = 0, bounds_check_instr = 0, zero_div = 0, clk_en = 1;
  logic [15:0] status_reg = 16'h2000;
  logic [23:0] fetch_addr = 24'h0;
  logic [3:0]  opcode_line = 4'h4, trap_num = 4'h0;
  logic [2:0]  int_level = 3'h0;
  logic [7:0]  ack_vec = 8'h0;
  logic [1:0]  ack_kind = 2'h0, lat = 2'h0;
  wire         bus_done, bus_autovec, bus_fault, bus_req, bus_write, ctx_load, exc_active;
  wire         start_fetch, ref_class_bit0, ref_class_bit1, ref_class_bit2;
  wire  [15:0] bus_rdata, bus_wdata, new_status;
  wire  [23:0] bus_addr, new_pc, new_ssp;
  wire  [7:0]  vec_num_q;
  int          num_errors = 0, checks_done = 0;
  logic [7:0]  ev [0:8] = '{8'd4, 8'd8, 8'd10, 8'd11, 8'd7, 8'd6, 8'd5, 8'd32, 8'd47};
  exception_vectoring_unit DUT (.core_clk, .rstn, .clk_en, .status_reg,
    .pc(24'h012344), .supervisor_stack_pointer(24'h000800), .instr_done, .cpu_data_ref,
    .reset_req, .bus_err, .word_fetch, .fetch_addr, .illegal_op, .privileged_op,
    .opcode_line, .trap_instr, .trap_num, .trap_on_overflow_instr, .bounds_check_instr,
    .zero_div, .int_level, .bus_done, .bus_autovec, .bus_fault, .bus_rdata, .bus_req,
    .bus_write, .bus_addr, .bus_wdata, .ref_class_bit0, .ref_class_bit1, .ref_class_bit2,
    .new_status, .new_pc, .new_ssp, .ctx_load, .exc_active, .vec_num_q, .start_fetch);
  exc_bus_model P (.core_clk, .bus_req, .bus_write, .bus_addr, .bus_wdata,
    .ref_class({ref_class_bit2, ref_class_bit1, ref_class_bit0}), .ack_vec, .ack_kind,
    .lat, .bus_done, .bus_autovec, .bus_fault, .bus_rdata);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // memory word at a is {~a[7:0], a[7:0]}; high word low byte gives pc bits 23:16
  function automatic logic [23:0] vpc(input logic [7:0] v);
    logic [7:0] a;
    logic [7:0] b;
    a = {v[5:0], 2'b00};
    b = a + 8'h2;
    return {a, ~b, b};
  endfunction
  // waits for the new context; vector 1 stands for the reset sequence
  task automatic run(input logic [7:0] v, input int nw, input bit clr_int);
    int base;
    int base6;
    int n;
    base = P.wr_n;
    base6 = P.rd6_n;
    n = 0;
    @(posedge core_clk);
    {instr_done, trap_instr, trap_on_overflow_instr, bounds_check_instr, zero_div} <= '0;
    {reset_req, bus_err, word_fetch, trap_num} <= '0;
    while (ctx_load !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (clr_int)
      int_level <= 3'h0;
    {illegal_op, privileged_op} <= '0;
    chk("context load", 24'h1, {23'h0, ctx_load});
    if (v != 8'h01)
      chk("vector number", {16'h0, v}, {16'h0, vec_num_q});
    chk("new pc", vpc(v), new_pc);
    chk("stack writes", 24'(nw), 24'(P.wr_n - base));
    chk("program reads", (v == 8'h01) ? 24'h4 : 24'h0, 24'(P.rd6_n - base6));
    if (nw != 0) begin
      chk("stacked pc", 24'h002344, {8'h0, P.wlog[base[5:0]]});
      chk("stacked status", {8'h0, status_reg}, {8'h0, P.wlog[base[5:0] + 6'h2]});
    end
  endtask
  task automatic irq(input logic [2:0] lvl, input logic [1:0] kind, input logic [7:0] v,
                     input logic [7:0] exp);
    @(posedge core_clk);
    int_level <= lvl;
    ack_kind <= kind;
    ack_vec <= v;
    lat <= lvl[1:0];
    instr_done <= 1'b1;
    run(exp, 3, 1);
    chk("int mask", {21'h0, lvl}, {21'h0, new_status[10:8]});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    num_errors++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      status_reg <= {i[1], 15'h0};
      cpu_data_ref <= i[0];
      @(posedge core_clk);
      #1;
      chk("idle class", {21'h0, i[1], ~i[0], i[0]}, {21'h0, ref_class_bit2, ref_class_bit1, ref_class_bit0});
    end
    $display("test idle class done");
    @(posedge core_clk);
    reset_req <= 1'b1;
    bus_err <= 1'b1;
    run(8'h01, 0, 0);
    chk("reset ssp", 24'h00fd02, new_ssp);
    chk("reset mask", 24'h7, {21'h0, new_status[10:8]});
    $display("test reset done");
    status_reg <= 16'h2000;
    irq(3'h3, 2'h0, 8'h05, 8'h05);
    irq(3'h1, 2'h0, 8'h40, 8'h40);
    irq(3'h6, 2'h0, 8'hff, 8'hff);
    irq(3'h4, 2'h0, 8'h0f, 8'h0f);
    irq(3'h2, 2'h2, 8'h00, 8'd24);
    for (int l = 1; l < 8; l++)
      irq(3'(l), 2'h1, 8'h00, 8'(24 + l));
    $display("test interrupts done");
    for (int k = 0; k < 9; k++) begin
      @(posedge core_clk);
      status_reg <= 16'h0300;
      instr_done <= 1'b1;
      opcode_line <= (k == 2) ? 4'ha : (k == 3) ? 4'hf : 4'h4;
      illegal_op <= (k == 0 || k == 2 || k == 3);
      privileged_op <= (k == 1);
      trap_on_overflow_instr <= (k == 4);
      bounds_check_instr <= (k == 5);
      zero_div <= (k == 6);
      trap_instr <= (k > 6);
      trap_num <= (k == 8) ? 4'hf : 4'h0;
      run(ev[k], 3, 0);
    end
    $display("test internal vectors done");
    @(posedge core_clk);
    bus_err <= 1'b1;
    trap_instr <= 1'b1;
    instr_done <= 1'b1;
    run(8'd2, 6, 0);
    @(posedge core_clk);
    word_fetch <= 1'b1;
    fetch_addr <= 24'h001234;
    repeat (3) @(posedge core_clk);
    chk("even fetch", 24'h0, {23'h0, exc_active});
    fetch_addr <= 24'h001235;
    clk_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("frozen abort", 24'h0, {23'h0, exc_active});
    clk_en <= 1'b1;
    run(8'd3, 6, 0);
    $display("test abort class done");
    @(posedge core_clk);
    status_reg <= 16'hc000;
    int_level <= 3'h2;
    ack_kind <= 2'h0;
    ack_vec <= 8'h70;
    illegal_op <= 1'b1;
    instr_done <= 1'b1;
    run(8'd9, 3, 0);
    run(8'h70, 3, 1);
    $display("test trace then interrupt done");
    finish_test;
  end
endmodule // testbench
`default_nettype wire
